// ---- rtl/nvsram_host_pkg.sv ----
package nvsram_host_pkg;
    // Clock
    localparam int unsigned CLK_PERIOD_NS        = 20;
    // Timing limits
    localparam int unsigned POWERUP_RECALL_MS    = 40;
    localparam int unsigned STORE_COM_US         = 12500;
    localparam int unsigned STORE_IND_US         = 15000;
    localparam int unsigned SOFT_RECALL_US       = 100;
    localparam int unsigned SOFT_SEQ_US          = 70;
    localparam int unsigned ACCESS_NS            = 45;
    localparam int unsigned STROBE_NS            = 30;
    // Derived cycle counts (least times rounded up)
    localparam int unsigned POWERUP_RECALL_CYC   = (POWERUP_RECALL_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STORE_COM_CYC        = (STORE_COM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STORE_IND_CYC        = (STORE_IND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SOFT_RECALL_CYC      = (SOFT_RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SOFT_SEQ_CYC         = (SOFT_SEQ_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACCESS_CYC           = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC           = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W              = 24;
    // Address and data widths and soft sequence
    localparam int unsigned ADDR_W               = 17;
    localparam int unsigned DATA_W               = 8;
    localparam logic [15:0] SEQ_A0               = 16'h4E38;
    localparam logic [15:0] SEQ_A1               = 16'hB1C7;
    localparam logic [15:0] SEQ_A2               = 16'h83E0;
    localparam logic [15:0] SEQ_A3               = 16'h7C1F;
    localparam logic [15:0] SEQ_A4               = 16'h703F;
    localparam logic [15:0] SEQ_STORE            = 16'h8FC0;
    localparam logic [15:0] SEQ_RECALL           = 16'h4C63;
    // Host commands
    localparam logic [1:0]  CMD_READ             = 2'h0;
    localparam logic [1:0]  CMD_WRITE            = 2'h1;
    localparam logic [1:0]  CMD_STORE            = 2'h2;
    localparam logic [1:0]  CMD_RECALL           = 2'h3;

    // Soft sequence address per step; the sixth is the store or recall address
    function automatic logic [15:0] seq_addr(input logic [2:0] step, input logic recall);
        case (step)
            3'h0:    seq_addr = SEQ_A0;
            3'h1:    seq_addr = SEQ_A1;
            3'h2:    seq_addr = SEQ_A2;
            3'h3:    seq_addr = SEQ_A3;
            3'h4:    seq_addr = SEQ_A4;
            default: seq_addr = recall ? SEQ_RECALL : SEQ_STORE;
        endcase
    endfunction
endpackage

// ---- rtl/nvsram_cyc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface nvsram_cyc_if;
    import nvsram_host_pkg::*;
    logic              start;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport ctl (output start, output wr, output addr, output wdata, input done, input rdata);
    modport cyc (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ---- rtl/nvsram_pin_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsram_pin_cycle
    import nvsram_host_pkg::*;
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_srst,
    // Cycle request
    nvsram_cyc_if.cyc              cyc,
    // Pins
    input  wire logic [DATA_W-1:0] i_byte_sync,
    output logic                   o_chip_sel_n,
    output logic                   o_wr_strobe_n,
    output logic                   o_out_gate_n,
    output logic [ADDR_W-1:0]      o_addr_lines,
    output logic [DATA_W-1:0]      o_byte_lines,
    output logic                   o_byte_oe_n
);
    typedef enum logic [1:0] {
        PC_IDLE   = 2'b00,
        PC_SETUP  = 2'b01,
        PC_STROBE = 2'b10,
        PC_END    = 2'b11
    } pc_state_e;

    // Strobe count: access and strobe cycles plus 2 extra for the synchroniser delay on read data
    localparam logic [3:0] HOLD_CYC = 4'(ACCESS_CYC + STROBE_CYC + 2);

    pc_state_e         st_q, st_d;
    logic [3:0]        cnt_q, cnt_d;
    logic              wr_q, wr_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic              done_q, done_d;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        wr_d   = wr_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        done_d = 1'b0;
        case (st_q)
            PC_IDLE: begin
                if (cyc.start) begin
                    // Address settles with both strobes high
                    st_d   = PC_SETUP;
                    wr_d   = cyc.wr;
                    addr_d = cyc.addr;
                    wdat_d = cyc.wdata;
                end
            end
            PC_SETUP: begin
                st_d  = PC_STROBE;
                cnt_d = HOLD_CYC;
            end
            PC_STROBE: begin
                if (cnt_q == 4'h0) begin
                    st_d   = PC_END;
                    rdat_d = i_byte_sync;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            PC_END: begin
                st_d   = PC_IDLE;
                done_d = 1'b1;
            end
            default: st_d = PC_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q   <= PC_IDLE;
            cnt_q  <= 4'h0;
            wr_q   <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            wr_q   <= wr_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            done_q <= done_d;
        end
    end

    // Strobes are low only in PC_STROBE, so address never moves under them
    assign o_chip_sel_n  = (st_q != PC_STROBE);
    assign o_wr_strobe_n = !(st_q == PC_STROBE && wr_q);
    assign o_out_gate_n  = !(st_q == PC_STROBE && !wr_q);
    assign o_addr_lines  = addr_q;
    assign o_byte_lines  = wdat_q;
    // Drive data from PC_SETUP through PC_END of a write so the bus never floats under the write strobe
    assign o_byte_oe_n   = !(st_q != PC_IDLE && wr_q);
    assign cyc.done      = done_q;
    assign cyc.rdata     = rdat_q;
endmodule // nvsram_pin_cycle
`default_nettype wire

// ---- rtl/nvsram_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Write strobe held high across every read cycle.
// - Address changes only while chip select or write strobe is high.
// - Each soft sequence step is a read, timed by gate or chip select.
// - Six consecutive reads in prescribed order, write strobe high.
// - Low 16 address bits compared; fixed lead-in, store or recall tail.
module nvsram_host
    import nvsram_host_pkg::*;
#(
    parameter int unsigned POWERUP_WAIT = POWERUP_RECALL_CYC,
    parameter int unsigned STORE_WAIT   = STORE_IND_CYC,
    parameter int unsigned RECALL_WAIT  = SOFT_RECALL_CYC + SOFT_SEQ_CYC,
    parameter int unsigned SEQ_WAIT     = SOFT_SEQ_CYC
) (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_srst,
    // Supply status
    input  wire logic              i_supply_ok,
    // Command port
    input  wire logic              i_cmd_valid,
    input  wire logic [1:0]        i_cmd_op,
    input  wire logic [ADDR_W-1:0] i_cmd_addr,
    input  wire logic [DATA_W-1:0] i_cmd_wdata,
    output logic                   o_cmd_ready,
    output logic                   o_rsp_valid,
    output logic [DATA_W-1:0]      o_rsp_rdata,
    output logic                   o_busy,
    // Device pins
    output logic                   o_chip_sel_n,
    output logic                   o_wr_strobe_n,
    output logic                   o_out_gate_n,
    output logic [ADDR_W-1:0]      o_addr_lines,
    input  wire logic [DATA_W-1:0] i_byte_lines,
    output logic [DATA_W-1:0]      o_byte_lines,
    output logic                   o_byte_oe_n,
    input  wire logic              i_hw_store_line_n,
    output logic                   o_hw_store_line_n,
    output logic                   o_hw_store_oe_n
);
    typedef enum logic [2:0] {
        H_PWRUP = 3'b000,
        H_IDLE  = 3'b001,
        H_ACC   = 3'b010,
        H_SEQ   = 3'b011,
        H_WAIT  = 3'b100
    } host_state_e;

    nvsram_cyc_if cyc ();

    // Pin synchronisers
    logic [DATA_W-1:0] byte_s1_q, byte_s2_q;
    logic [1:0]        sup_s_q;
    logic [1:0]        store_s_q;

    host_state_e       st_q, st_d;
    logic [TIMER_W-1:0] tmr_q, tmr_d;
    logic [2:0]        step_q, step_d;
    logic              rcl_q, rcl_d;
    logic              start_q, start_d;
    logic              wr_q, wr_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d;
    logic              rsp_q, rsp_d;
    logic [DATA_W-1:0] rdat_q, rdat_d;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            byte_s1_q <= '0;
            byte_s2_q <= '0;
            sup_s_q   <= 2'h0;
            store_s_q <= 2'h3;
        end else begin
            byte_s1_q <= i_byte_lines;
            byte_s2_q <= byte_s1_q;
            sup_s_q   <= {sup_s_q[0], i_supply_ok};
            store_s_q <= {store_s_q[0], i_hw_store_line_n};
        end
    end

    // Device busy with low supply or a store in progress on the store line
    logic dev_locked;
    assign dev_locked = !sup_s_q[1] || !store_s_q[1];

    always_comb begin
        st_d    = st_q;
        tmr_d   = tmr_q;
        step_d  = step_q;
        rcl_d   = rcl_q;
        start_d = 1'b0;
        wr_d    = wr_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        rsp_d   = 1'b0;
        rdat_d  = rdat_q;
        case (st_q)
            H_PWRUP: begin
                // Hold off while supply is low, then wait out the power-up copy
                if (!sup_s_q[1]) begin
                    tmr_d = TIMER_W'(POWERUP_WAIT);
                end else if (tmr_q == '0) begin
                    st_d = H_IDLE;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
            H_IDLE: begin
                if (!sup_s_q[1]) begin
                    st_d = H_PWRUP;
                end else if (i_cmd_valid && !dev_locked) begin
                    if (i_cmd_op == CMD_READ || i_cmd_op == CMD_WRITE) begin
                        st_d    = H_ACC;
                        start_d = 1'b1;
                        wr_d    = (i_cmd_op == CMD_WRITE);
                        addr_d  = i_cmd_addr;
                        wdat_d  = i_cmd_wdata;
                    end else begin
                        st_d    = H_SEQ;
                        start_d = 1'b1;
                        step_d  = 3'h0;
                        rcl_d   = (i_cmd_op == CMD_RECALL);
                        wr_d    = 1'b0;
                        addr_d  = {1'b0, seq_addr(3'h0, i_cmd_op == CMD_RECALL)};
                    end
                end
            end
            H_ACC: begin
                if (cyc.done) begin
                    st_d   = H_IDLE;
                    rsp_d  = 1'b1;
                    rdat_d = wr_q ? 8'h00 : cyc.rdata;
                end
            end
            H_SEQ: begin
                // Back-to-back reads; no other cycle can slip between them
                if (cyc.done) begin
                    if (step_q == 3'h5) begin
                        st_d  = H_WAIT;
                        tmr_d = rcl_q ? TIMER_W'(RECALL_WAIT) : TIMER_W'(STORE_WAIT + SEQ_WAIT);
                    end else begin
                        step_d  = step_q + 3'h1;
                        start_d = 1'b1;
                        addr_d  = {1'b0, seq_addr(step_q + 3'h1, rcl_q)};
                    end
                end
            end
            H_WAIT: begin
                if (tmr_q == '0) begin
                    st_d  = H_IDLE;
                    rsp_d = 1'b1;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
            default: st_d = H_PWRUP;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q    <= H_PWRUP;
            tmr_q   <= '0;
            step_q  <= 3'h0;
            rcl_q   <= 1'b0;
            start_q <= 1'b0;
            wr_q    <= 1'b0;
            addr_q  <= '0;
            wdat_q  <= '0;
            rsp_q   <= 1'b0;
            rdat_q  <= '0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            step_q  <= step_d;
            rcl_q   <= rcl_d;
            start_q <= start_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            wdat_q  <= wdat_d;
            rsp_q   <= rsp_d;
            rdat_q  <= rdat_d;
        end
    end

    assign cyc.start = start_q;
    assign cyc.wr    = wr_q;
    assign cyc.addr  = addr_q;
    assign cyc.wdata = wdat_q;

    nvsram_pin_cycle u_cycle (
        .i_ref_clk     (i_ref_clk),
        .i_srst        (i_srst),
        .cyc           (cyc),
        .i_byte_sync   (byte_s2_q),
        .o_chip_sel_n  (o_chip_sel_n),
        .o_wr_strobe_n (o_wr_strobe_n),
        .o_out_gate_n  (o_out_gate_n),
        .o_addr_lines  (o_addr_lines),
        .o_byte_lines  (o_byte_lines),
        .o_byte_oe_n   (o_byte_oe_n)
    );

    // Host never pulses the store line; it only watches it
    assign o_hw_store_line_n = 1'b1;
    assign o_hw_store_oe_n   = 1'b1;
    assign o_cmd_ready       = (st_q == H_IDLE) && sup_s_q[1] && !dev_locked;
    assign o_rsp_valid       = rsp_q;
    assign o_rsp_rdata       = rdat_q;
    assign o_busy            = (st_q != H_IDLE);
endmodule // nvsram_host
`default_nettype wire

// ---- verification/nvsram_host_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_monitor
    import nvsram_host_pkg::*;
(
    // Clock and reset
    input wire logic              i_ref_clk,
    input wire logic              i_srst,
    // Command side
    input wire logic              i_supply_ok,
    input wire logic              i_cmd_valid,
    input wire logic [1:0]        i_cmd_op,
    input wire logic              o_cmd_ready,
    input wire logic              o_rsp_valid,
    input wire logic              o_busy,
    // Device pins
    input wire logic              o_chip_sel_n,
    input wire logic              o_wr_strobe_n,
    input wire logic              o_out_gate_n,
    input wire logic [ADDR_W-1:0] o_addr_lines,
    input wire logic              o_byte_oe_n,
    input wire logic              i_hw_store_line_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    sequence soft_take;
        i_cmd_valid && o_cmd_ready && i_cmd_op[1];
    endsequence
    sequence sel_at(logic [15:0] a);
        $fell(o_chip_sel_n) && o_addr_lines == {1'b0, a};
    endsequence

    chk_read_we_high: assert property (!o_out_gate_n |-> o_wr_strobe_n)
        else $error("gate low while write strobe low");
    chk_addr_hold: assert property (!o_chip_sel_n && !$past(o_chip_sel_n) |-> $stable(o_addr_lines))
        else $error("address moved while selected");
    chk_sel_width: assert property ($fell(o_chip_sel_n) |-> !o_chip_sel_n [*7])
        else $error("select pulse too short");
    chk_sel_leads_we: assert property ($fell(o_wr_strobe_n) |-> !o_chip_sel_n)
        else $error("write strobe fell before select");
    chk_write_drive: assert property (!o_wr_strobe_n |-> !o_byte_oe_n)
        else $error("write without driven data");
    chk_busy_ready: assert property (o_busy |-> !o_cmd_ready)
        else $error("ready while busy");
    chk_supply_block: assert property (!i_supply_ok [*3] |-> !o_cmd_ready)
        else $error("ready with supply low");
    chk_store_block: assert property (!i_hw_store_line_n [*3] |-> !o_cmd_ready)
        else $error("ready while store line low");
    chk_seq_first: assert property (soft_take |-> ##[1:8] sel_at(SEQ_A0))
        else $error("soft sequence did not open with lead address");
    chk_seq_tail: assert property (sel_at(SEQ_A4) |-> o_wr_strobe_n throughout ##[8:16] ($fell(o_chip_sel_n)
        && (o_addr_lines == {1'b0, SEQ_STORE} || o_addr_lines == {1'b0, SEQ_RECALL})))
        else $error("soft sequence tail wrong");
    chk_read_rsp: assert property (i_cmd_valid && o_cmd_ready && i_cmd_op == CMD_READ |-> ##[10:16] o_rsp_valid)
        else $error("read response late");
endmodule // nvsram_host_monitor

bind nvsram_host nvsram_host_monitor i_mon (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_supply_ok(i_supply_ok), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_busy(o_busy),
    .o_chip_sel_n(o_chip_sel_n), .o_wr_strobe_n(o_wr_strobe_n), .o_out_gate_n(o_out_gate_n),
    .o_addr_lines(o_addr_lines), .o_byte_oe_n(o_byte_oe_n), .i_hw_store_line_n(i_hw_store_line_n)
);
`default_nettype wire

// ---- verification/nvsram_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsram_dev_model
    import nvsram_host_pkg::*;
#(
    parameter int STORE_NS  = 200,
    parameter int RECALL_NS = 100,
    parameter int SEQ_NS    = 40
) (
    // Host pins
    input  wire logic              i_chip_sel_n,
    input  wire logic              i_wr_strobe_n,
    input  wire logic              i_out_gate_n,
    input  wire logic [ADDR_W-1:0] i_addr_lines,
    input  wire logic [DATA_W-1:0] i_byte_lines,
    input  wire logic              i_supply_ok,
    // Device outputs
    output logic [DATA_W-1:0]      o_byte_lines,
    output logic                   o_hw_store_line_n
);
    localparam logic [15:0] LEAD [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [DATA_W-1:0] sram_q [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] nv_q   [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last_q;
    logic              busy_q;
    logic              dirty_q;
    logic              rd;
    logic              wr;
    int                step_q;

    assign rd = !i_chip_sel_n && !i_out_gate_n && i_wr_strobe_n && o_hw_store_line_n && !busy_q && i_supply_ok;
    assign wr = !i_chip_sel_n && !i_wr_strobe_n && o_hw_store_line_n && !busy_q && i_supply_ok;
    // Released bus shows the inverse of the last byte so a stale value never passes
    always @* if (rd) last_q = sram_q[i_addr_lines];
    assign o_byte_lines = rd ? sram_q[i_addr_lines] : ~last_q;

    task automatic nv_cycle(input logic store, input int ns);
        busy_q = 1'b1;
        o_hw_store_line_n = !store;
        #(ns);
        if (store) nv_q = sram_q;
        else sram_q = nv_q;
        dirty_q = 1'b0;
        o_hw_store_line_n = 1'b1;
        busy_q = 1'b0;
    endtask

    initial begin
        busy_q = 1'b0;
        dirty_q = 1'b0;
        step_q = 0;
        last_q = 8'h00;
        o_hw_store_line_n = 1'b1;
        nv_q[5] = 8'hA5;
    end
    always @(negedge wr) begin
        sram_q[i_addr_lines] = i_byte_lines;
        dirty_q = 1'b1;
        step_q = 0;
    end
    always @(negedge rd) if (!busy_q) begin
        if (step_q == 5) begin
            step_q = 0;
            if (i_addr_lines[15:0] == SEQ_STORE) begin
                #(SEQ_NS) nv_cycle(1'b1, STORE_NS);
            end else if (i_addr_lines[15:0] == SEQ_RECALL) begin
                #(SEQ_NS) nv_cycle(1'b0, RECALL_NS);
            end
        end else begin
            step_q = (i_addr_lines[15:0] == LEAD[step_q]) ? step_q + 1 : int'(i_addr_lines[15:0] == SEQ_A0);
        end
    end
    // Store on power loss only when something was written
    always @(negedge i_supply_ok) if (dirty_q) nv_cycle(1'b1, STORE_NS);
    always @(posedge i_supply_ok) nv_cycle(1'b0, RECALL_NS / 2);
endmodule // nvsram_dev_model
`default_nettype wire

// ---- verification/test_nvsram_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_nvsram_host
    import nvsram_host_pkg::*;
;
    localparam int PU_WAIT = 20;
    logic clk, srst, supply_ok, cmd_valid, cmd_ready, rsp_valid, busy, cs_n, we_n, gate_n;
    logic byte_oe_n, dev_store_n, hs_out, hs_oe_n, store_wire;
    logic [1:0] cmd_op;
    logic [ADDR_W-1:0] cmd_addr, addr_lines;
    logic [DATA_W-1:0] cmd_wdata, rsp_rdata, dev_byte, host_byte, q;
    int err_total, comparisons, cyc;

    assign store_wire = dev_store_n & (hs_oe_n | hs_out);
    nvsram_host #(.POWERUP_WAIT(PU_WAIT), .STORE_WAIT(10), .RECALL_WAIT(10), .SEQ_WAIT(5)) i_dut (
        .i_ref_clk(clk), .i_srst(srst), .i_supply_ok(supply_ok), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
        .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
        .o_rsp_rdata(rsp_rdata), .o_busy(busy), .o_chip_sel_n(cs_n), .o_wr_strobe_n(we_n),
        .o_out_gate_n(gate_n), .o_addr_lines(addr_lines), .i_byte_lines(dev_byte), .o_byte_lines(host_byte),
        .o_byte_oe_n(byte_oe_n), .i_hw_store_line_n(store_wire), .o_hw_store_line_n(hs_out),
        .o_hw_store_oe_n(hs_oe_n));
    nvsram_dev_model i_dev (
        .i_chip_sel_n(cs_n), .i_wr_strobe_n(we_n), .i_out_gate_n(gate_n), .i_addr_lines(addr_lines),
        .i_byte_lines(host_byte), .i_supply_ok(supply_ok), .o_byte_lines(dev_byte),
        .o_hw_store_line_n(dev_store_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic run_cmd(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= d;
        do begin @(negedge clk); n++; end while (cmd_ready !== 1'b1 && n < 3000);
        @(posedge clk);
        cmd_valid <= 1'b0;
        do begin @(negedge clk); n++; end while (rsp_valid !== 1'b1 && n < 3000);
        q = rsp_rdata;
        chk(n < 3000, 1'b1, "command hung");
    endtask

    task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp, input string what);
        run_cmd(CMD_READ, a, 8'h00);
        chk(q, exp, what);
    endtask

    task automatic t_powerup();
        int n;
        repeat (5) @(negedge clk);
        chk(busy, 1'b1, "busy before supply");
        chk({hs_oe_n, hs_out}, 2'h3, "store line released");
        chk(cmd_ready, 1'b0, "ready before supply");
        chk(cs_n, 1'b1, "select idle");
        @(posedge clk);
        supply_ok <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (cmd_ready !== 1'b1 && n < 500);
        chk(n >= PU_WAIT && n < 500, 1'b1, "power-up wait");
        rd_chk(17'h00005, 8'hA5, "recalled byte");
        $display("test powerup done");
    endtask

    task automatic t_rw();
        logic [16:0] a [4] = '{17'h00000, 17'h1FFFF, 17'h10005, 17'h0ABCD};
        logic [7:0]  d [4] = '{8'h11, 8'hEE, 8'h5A, 8'hC3};
        foreach (a[i]) begin
            run_cmd(CMD_WRITE, a[i], d[i]);
            chk(q, 8'h00, "write response data");
        end
        foreach (a[i]) rd_chk(a[i], d[i], "read back");
        rd_chk(17'h00005, 8'hA5, "bit 16 aliasing");
        $display("test read_write done");
    endtask

    task automatic t_soft();
        run_cmd(CMD_WRITE, 17'h00020, 8'h3C);
        run_cmd(CMD_STORE, 17'h00000, 8'h00);
        run_cmd(CMD_WRITE, 17'h00020, 8'hC3);
        rd_chk(17'h00020, 8'hC3, "after store write");
        run_cmd(CMD_RECALL, 17'h00000, 8'h00);
        rd_chk(17'h00020, 8'h3C, "recalled after soft recall");
        $display("test soft_store_recall done");
    endtask

    task automatic t_power_cycle();
        run_cmd(CMD_WRITE, 17'h00030, 8'h5A);
        @(posedge clk);
        supply_ok <= 1'b0;
        repeat (5) @(negedge clk);
        chk(cmd_ready, 1'b0, "ready with supply low");
        repeat (20) @(posedge clk);
        supply_ok <= 1'b1;
        rd_chk(17'h00030, 8'h5A, "kept over power loss");
        $display("test power_cycle done");
    endtask

    initial begin
        err_total = 0;
        comparisons = 0;
        cyc = 0;
        srst = 1'b1;
        supply_ok = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = CMD_READ;
        cmd_addr = '0;
        cmd_wdata = 8'h00;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_powerup();
        t_rw();
        t_soft();
        t_power_cycle();
        stop_test();
    end
endmodule // test_nvsram_host
`default_nettype wire
